/* dra_align.sv */
// Alignment-mode command handler and input image formatter, AXI4-Lite slave
//
// Contract
// RULE1: Input word 0 is module status; words 1 and 5 are channel statuses.
// RULE2: Before alignment, coarse in word 3, fine in word 7, rest zero.
// RULE3: Resolver positions in alignment mode use 1024 counts per turn.
// RULE4: Fault indications follow the live fault, never latched, in alignment mode.
// RULE5: Coarse resolver must be wired to channel 1, fine to channel 2.
// RULE6: Command 16#9001 computes coarse offset aligning both resolvers.
// RULE7: Coarse offset is internal, apart from the user preset offset.
// RULE8: Align answer sets acknowledge and result code in bits 3..0.
// RULE9: Align rejected with code 1 when configured for single resolvers.
// RULE10: Align rejected with code 1 when either channel has a fault.
// RULE11: Once aligned, 32-bit position in words 2-3, statuses kept, rest zero.
// RULE12: Right after alignment the position sits halfway through turn one.
// RULE13: Multi-turn position scaled by the full-scale count.
// RULE14: Low word holds bits 15..0, high word the upper bits.
// RULE15: New offset applied only on exit; discarded on plain exit or reset.
// RULE16: Command 16#800E acknowledges and saves offset to non-volatile memory.
// RULE17: After save and exit, move to measurement mode.
// RULE18: Commands taken on 0-to-1 of transmit bit; its clear clears acknowledge.
// RULE19: 16#9000 with password 16#1298 enters alignment, else error code 1.
// RULE20: Response words updated before acknowledge becomes visible.
`timescale 1ns/10ps
module dra_align #(
  parameter int unsigned RES_W = dra_pkg::RES_BITS,
  parameter int unsigned FSC_W = dra_pkg::FSC_BITS
) (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic                       ce,
  input  wire logic [dra_pkg::DRA_AW-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [dra_pkg::DRA_AW-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic [RES_W-1:0]           coarse_pos,
  input  wire logic [RES_W-1:0]           fine_pos,
  input  wire logic                       ch1_fault,
  input  wire logic                       ch2_fault,
  input  wire logic                       nvm_aligned,
  output logic                            nvm_wr_stb,
  output logic [2*RES_W-1:0]              nvm_wr_offset
);
  import dra_pkg::*;

  initial begin
    if (RES_W != RES_BITS || FSC_W != FSC_BITS) begin
      $error("dra_align: resolver and scale widths are fixed by the image layout");
    end
  end

  function automatic logic [3:0] word_idx(input logic [DRA_AW-1:0] addr, input logic [DRA_AW-1:0] base);
    logic [DRA_AW-1:0] rel;
    rel = addr - base;
    if (addr < base || rel[1:0] != 2'h0 || rel[DRA_AW-1:2] >= (DRA_AW-2)'(DRA_WORDS)) begin
      word_idx = NO_WORD;
    end else begin
      word_idx = rel[5:2];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [15:0]        out_img_q [DRA_WORDS];
  logic [15:0]        in_img_q  [DRA_WORDS];
  logic [15:0]        in_img_d  [DRA_WORDS];
  logic               cfg_dual_q;
  logic [FSC_W-1:0]   fsc_q;
  dra_mode_t          mode_q;
  logic               aligned_q;
  logic [2*RES_W-1:0] offset_q;
  logic               tx_prev_q;
  logic               ack_q;
  logic               ack_pend_q;
  logic [3:0]         err_q;
  logic [31:0]        mt_pos;
  logic               cmd_stb;
  logic [15:0]        cmd;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  logic              aw_q;
  logic              w_q;
  logic [DRA_AW-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              wr_do;
  logic [3:0]        wr_idx;

  assign s_axi_awready = ce & ~aw_q & ~bvalid_q;
  assign s_axi_wready  = ce & ~w_q & ~bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign wr_do         = ce & aw_q & w_q;
  assign wr_idx        = word_idx(awaddr_q, OUT_BASE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= '0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_do) begin
        aw_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_do) begin
        w_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (ce) begin
      if (wr_do) begin
        bvalid_q <= 1'b1;
        bresp_q  <= (wr_idx != NO_WORD || awaddr_q == CFG_ADDR || awaddr_q == FSC_ADDR) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Output command image: 16-bit words in the low two byte lanes
  for (genvar g = 0; g < DRA_WORDS; g++) begin : g_out
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        out_img_q[g] <= 16'h0000;
      end else if (ce && wr_do && wr_idx == 4'(g)) begin
        if (wstrb_q[0]) begin
          out_img_q[g][7:0] <= wdata_q[7:0];
        end
        if (wstrb_q[1]) begin
          out_img_q[g][15:8] <= wdata_q[15:8];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_dual_q <= CFG_DUAL_RST;
      fsc_q      <= FSC_RST;
    end else if (ce && wr_do) begin
      if (awaddr_q == CFG_ADDR && wstrb_q[0]) begin
        cfg_dual_q <= wdata_q[CFG_DUAL_BIT];
      end
      if (awaddr_q == FSC_ADDR) begin
        for (int b = 0; b < 3; b++) begin
          if (wstrb_q[b]) begin
            fsc_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [3:0]  rd_out;
  logic [3:0]  rd_in;

  assign s_axi_arready = ce & ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign rd_out        = word_idx(s_axi_araddr, OUT_BASE);
  assign rd_in         = word_idx(s_axi_araddr, IN_BASE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_q <= 1'b1;
        rresp_q  <= RESP_OKAY;
        if (rd_out != NO_WORD) begin
          rdata_q <= {16'h0000, out_img_q[rd_out]};
        end else if (rd_in != NO_WORD) begin
          rdata_q <= {16'h0000, in_img_q[rd_in]};
        end else if (s_axi_araddr == CFG_ADDR) begin
          rdata_q <= 32'(cfg_dual_q);
        end else if (s_axi_araddr == FSC_ADDR) begin
          rdata_q <= 32'(fsc_q);
        end else if (s_axi_araddr == STAT_ADDR) begin
          rdata_q <= {28'h0000000, aligned_q, mode_q == DRA_MEAS, mode_q == DRA_ALIGN, ack_q};
        end else begin
          rdata_q <= 32'h00000000;
          rresp_q <= RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command handling
  assign cmd     = out_img_q[0];
  assign cmd_stb = cmd[TX_BIT] & ~tx_prev_q;  // RULE18

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_prev_q <= 1'b0;
    end else if (ce) begin
      tx_prev_q <= cmd[TX_BIT];
    end
  end

  // Acknowledge lags the state change by one edge so that the image is fresh first
  // Set wins over a same-cycle clear so that no answer is ever lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_pend_q <= 1'b0;
      ack_q      <= 1'b0;
    end else if (ce) begin
      ack_pend_q <= cmd_stb;
      if (ack_pend_q) begin
        ack_q <= 1'b1;  // RULE20 RULE8 RULE16
      end else if (!cmd[TX_BIT]) begin
        ack_q <= 1'b0;  // RULE18
      end
    end
  end

  // Reset drops any unsaved offset: only the non-volatile copy survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q        <= DRA_IDLE;
      aligned_q     <= 1'b0;
      offset_q      <= OFFSET_RST;  // RULE15
      err_q         <= ERR_NONE;
      nvm_wr_stb    <= 1'b0;
      nvm_wr_offset <= OFFSET_RST;
    end else if (ce) begin
      nvm_wr_stb <= 1'b0;
      if (cmd_stb) begin
        err_q <= ERR_NONE;
        if (cmd == CMD_ENTER) begin
          if (out_img_q[1] == PASSWORD) begin
            mode_q    <= DRA_ALIGN;  // RULE19
            aligned_q <= 1'b0;
          end else begin
            err_q <= ERR_CMD;  // RULE19
          end
        end else if (mode_q != DRA_ALIGN) begin
          err_q <= ERR_CMD;
        end else begin
          case (cmd)
            CMD_ALIGN: begin
              if (!cfg_dual_q || ch1_fault || ch2_fault) begin
                err_q <= ERR_CMD;  // RULE9 RULE10
              end else begin
                // Internal offset only; the user preset offset lives elsewhere
                offset_q  <= {coarse_pos, fine_pos} - HALF_TURN;  // RULE6 RULE7 RULE12
                aligned_q <= 1'b1;
              end
            end
            CMD_SAVE_EXIT: begin
              if (aligned_q) begin
                nvm_wr_stb    <= 1'b1;  // RULE16 RULE15
                nvm_wr_offset <= offset_q;
                mode_q        <= DRA_MEAS;  // RULE17
                aligned_q     <= 1'b0;
              end else begin
                err_q <= ERR_CMD;
              end
            end
            CMD_EXIT: begin
              aligned_q <= 1'b0;  // RULE15
              mode_q    <= nvm_aligned ? DRA_MEAS : DRA_ALIGN;
            end
            default: begin
              err_q <= ERR_CMD;
            end
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input image
  dra_mt_pos #(
    .RES_W (RES_W),
    .FSC_W (FSC_W)
  ) u_pos (
    .coarse (coarse_pos),
    .fine   (fine_pos),
    .offset (offset_q),
    .fsc    (fsc_q),
    .pos    (mt_pos)
  );

  always_comb begin
    for (int i = 0; i < DRA_WORDS; i++) begin
      in_img_d[i] = 16'h0000;  // RULE2 RULE11
    end
    in_img_d[0][ACK_BIT]     = ack_q;  // RULE1 RULE8
    in_img_d[0][INALIGN_BIT] = (mode_q == DRA_ALIGN);
    in_img_d[0][ALIGNED_BIT] = aligned_q;
    in_img_d[0][INMEAS_BIT]  = (mode_q == DRA_MEAS);
    in_img_d[0][3:0]         = err_q;  // RULE8
    if (mode_q == DRA_ALIGN) begin
      // Live fault levels: they vanish with the condition
      in_img_d[1][FAULT_BIT] = ch1_fault;  // RULE4 RULE1
      in_img_d[5][FAULT_BIT] = ch2_fault;  // RULE4 RULE1
      if (aligned_q) begin
        in_img_d[2] = mt_pos[31:16];  // RULE11 RULE14
        in_img_d[3] = mt_pos[15:0];  // RULE14
      end else begin
        // Channel 1 carries the coarse resolver, channel 2 the fine one
        in_img_d[3] = 16'(coarse_pos);  // RULE2 RULE3 RULE5
        in_img_d[7] = 16'(fine_pos);  // RULE2 RULE3 RULE5
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < DRA_WORDS; i++) begin
        in_img_q[i] <= 16'h0000;
      end
    end else if (ce) begin
      for (int i = 0; i < DRA_WORDS; i++) begin
        in_img_q[i] <= in_img_d[i];
      end
    end
  end

endmodule

/* dra_align_chk.sv */
// Port-level checks for the alignment block
`timescale 1ns/10ps
module dra_align_chk #(
  parameter int unsigned RES_W = 10,
  parameter int unsigned FSC_W = 24
) (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               ce,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire logic               nvm_wr_stb,
  input wire logic [2*RES_W-1:0] nvm_wr_offset
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped before taken");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed before taken");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_AR_BLK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  AST_AW_BLK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready ##1 ce |=> s_axi_bvalid)
    else $error("write answer late");
  AST_CE_OFF: assert property (!ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
    else $error("ready high while clock enable low");
  AST_STB_PULSE: assert property (nvm_wr_stb && ce |=> !nvm_wr_stb)
    else $error("store strobe longer than one cycle");
  AST_STB_OFS: assert property (nvm_wr_stb |=> $stable(nvm_wr_offset))
    else $error("stored offset moved after strobe");
  AST_OFS_HOLD: assert property ($changed(nvm_wr_offset) |-> nvm_wr_stb)
    else $error("stored offset moved without strobe");
endmodule
bind dra_align dra_align_chk #(.RES_W(RES_W), .FSC_W(FSC_W)) u_chk (.aclk, .aresetn, .ce, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .nvm_wr_stb, .nvm_wr_offset);

/* dra_mt_pos.sv */
// Multi-turn position: coarse/fine combination, internal offset and scaling
`timescale 1ns/10ps
module dra_mt_pos #(
  parameter int unsigned RES_W = dra_pkg::RES_BITS,
  parameter int unsigned FSC_W = dra_pkg::FSC_BITS
) (
  input  wire logic [RES_W-1:0]   coarse,
  input  wire logic [RES_W-1:0]   fine,
  input  wire logic [2*RES_W-1:0] offset,
  input  wire logic [FSC_W-1:0]   fsc,
  output logic      [31:0]        pos
);
  import dra_pkg::*;

  logic [2*RES_W-1:0]       raw;
  logic [2*RES_W+FSC_W-1:0] prod;

  initial begin
    if (RES_W < 2 || FSC_W > 32 || FSC_W < 2) begin
      $error("dra_mt_pos: unsupported width");
    end
  end

  // Offset subtraction wraps modulo the raw span, as the turns counter does
  assign raw  = {coarse, fine} - offset;
  // Full-scale count spans the whole raw range
  assign prod = (2*RES_W+FSC_W)'(raw) * (2*RES_W+FSC_W)'(fsc);  // RULE13
  assign pos  = 32'(prod[2*RES_W+FSC_W-1:2*RES_W]);
endmodule

/* dra_pkg.sv */
// Constants, types and register map of the dual-resolver alignment block
package dra_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Network image
  localparam int unsigned   DRA_WORDS     = 10;
  localparam int unsigned   DRA_AW        = 8;
  localparam logic [7:0]    OUT_BASE      = 8'h00;
  localparam logic [7:0]    IN_BASE       = 8'h40;
  localparam logic [7:0]    CFG_ADDR      = 8'h80;
  localparam logic [7:0]    FSC_ADDR      = 8'h84;
  localparam logic [7:0]    STAT_ADDR     = 8'h88;
  localparam logic [3:0]    NO_WORD       = 4'hF;

  ////////////////////////////////////////////////////////////////////////////
  // Command codes and field positions
  localparam logic [15:0]   CMD_ENTER     = 16'h9000;
  localparam logic [15:0]   CMD_ALIGN     = 16'h9001;
  localparam logic [15:0]   CMD_SAVE_EXIT = 16'h800E;
  localparam logic [15:0]   CMD_EXIT      = 16'h800F;
  localparam logic [15:0]   PASSWORD      = 16'h1298;
  localparam int unsigned   TX_BIT        = 15;
  localparam int unsigned   ACK_BIT       = 15;
  localparam int unsigned   INALIGN_BIT   = 14;
  localparam int unsigned   ALIGNED_BIT   = 13;
  localparam int unsigned   INMEAS_BIT    = 12;
  localparam int unsigned   FAULT_BIT     = 0;
  localparam int unsigned   CFG_DUAL_BIT  = 0;
  localparam logic [3:0]    ERR_NONE      = 4'h0;
  localparam logic [3:0]    ERR_CMD       = 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Resolver geometry and reset values
  localparam int unsigned   RES_BITS      = 10;
  localparam int unsigned   RES_COUNTS    = 1024;
  localparam int unsigned   RAW_BITS      = 2 * RES_BITS;
  localparam int unsigned   FSC_BITS      = 24;
  localparam logic [19:0]   HALF_TURN     = 20'h00200;
  localparam logic [23:0]   FSC_RST       = 24'h100000;
  localparam logic          CFG_DUAL_RST  = 1'b0;
  localparam logic [19:0]   OFFSET_RST    = 20'h00000;

  ////////////////////////////////////////////////////////////////////////////
  // Bus answers
  localparam logic [1:0]    RESP_OKAY     = 2'h0;
  localparam logic [1:0]    RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {DRA_IDLE, DRA_ALIGN, DRA_MEAS} dra_mode_t;

endpackage

/* dra_xdcr.sv */
// Resolver pair and non-volatile store model at the far side of the alignment block
`timescale 1ns/10ps
module dra_xdcr (
  input  wire logic        aclk,
  input  wire logic [19:0] shaft,
  input  wire logic        flt1,
  input  wire logic        flt2,
  input  wire logic        nvm_wr_stb,
  input  wire logic [19:0] nvm_wr_offset,
  output logic      [9:0]  coarse_pos,
  output logic      [9:0]  fine_pos,
  output logic             ch1_fault,
  output logic             ch2_fault,
  output logic             nvm_aligned,
  output logic      [19:0] saved_q
);
  ////////////////////////////////////////////////////////////////////////////
  // Reduction gearing: the coarse resolver counts turns of the fine one
  assign coarse_pos = shaft[19:10];
  assign fine_pos   = shaft[9:0];
  assign ch1_fault  = flt1;
  assign ch2_fault  = flt2;
  ////////////////////////////////////////////////////////////////////////////
  // Store survives block reset on purpose, so it has no reset branch
  initial begin
    nvm_aligned = 1'h0;
    saved_q     = 20'h00000;
  end
  always @(posedge aclk) begin
    if (nvm_wr_stb) begin
      nvm_aligned <= 1'h1;
      saved_q     <= nvm_wr_offset;
    end
  end
endmodule

/* tb_dra_align.sv */
// Self-checking bench for the alignment block
`timescale 1ns/10ps
module tb_dra_align;
  import dra_pkg::*;
  logic        aclk = 1'h0, aresetn = 1'h0, ce = 1'h1, flt1 = 1'h0, flt2 = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        nvm_wr_stb, nvm_aligned, ch1_fault, ch2_fault;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [9:0]  coarse_pos, fine_pos;
  logic [19:0] shaft = 20'h0, raw0, d20, nvm_wr_offset, saved_q;
  logic [23:0] fsc;
  logic [43:0] prod;
  logic [34:0] q[$], ent;
  logic [15:0] bad [4] = '{CMD_ALIGN, CMD_SAVE_EXIT, CMD_EXIT, 16'h8800};
  int          err_total = 0, checks = 0;

  always #12.5 aclk = ~aclk;
  dra_align DUT (.*);
  dra_xdcr u_xdcr (.*);

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 40) begin
      err_total++;
      $display("wait limit reached at %0t", $time);
      end_sim();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Bus master: one transfer at a time, payload held until its ready
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
    int n;
    @(posedge aclk);
    q.push_back({1'h1, r, 32'h0});
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'h0;
    tmo(n);
  endtask
  task automatic rq(input logic [7:0] a, input logic [34:0] e, output logic [31:0] v);
    int n;
    @(posedge aclk);
    q.push_back(e);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    v = s_axi_rdata;
    s_axi_rready <= 1'h0;
    tmo(n);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    logic [31:0] v;
    rq(a, {1'h1, r, e}, v);
  endtask
  task automatic poll(input logic v);
    logic [31:0] w;
    int n;
    for (n = 0; n < 40; n++) begin
      rq(IN_BASE, 35'h0, w);
      if (w[ACK_BIT] === v) break;
    end
    tmo(n);
  endtask
  task automatic cmd(input logic [15:0] c, input logic [15:0] p, input logic [31:0] e);
    wr(8'h04, {16'h0, p}, RESP_OKAY);
    wr(OUT_BASE, {16'h0, c}, RESP_OKAY);
    poll(1'h1);
    rd(IN_BASE, e, RESP_OKAY);
  endtask
  task automatic clr;
    wr(OUT_BASE, 32'h0, RESP_OKAY);
    poll(1'h0);
  endtask
  task automatic img(input logic [15:0] w1, w2, w3, w5, w7);
    logic [15:0] e [10];
    e = '{16'h0, w1, w2, w3, 16'h0, w5, 16'h0, w7, 16'h0, 16'h0};
    for (int i = 1; i < 10; i++) rd(IN_BASE + 8'(4 * i), {16'h0, e[i]}, RESP_OKAY);
  endtask
  task automatic align;
    shaft <= 20'($urandom);
    cmd(CMD_ENTER, PASSWORD, 32'hC000);
    clr();
    raw0 = shaft;
    cmd(CMD_ALIGN, 16'h0, 32'hE000);
    img(16'h0, 16'h0, 16'h0200, 16'h0, 16'h0);
    clr();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Results seen on the bus are matched against the oldest note
  always @(posedge aclk) begin
    if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) begin
      ent = q.pop_front();
      if (ent[34]) chk(s_axi_rvalid ? {s_axi_rresp, s_axi_rdata} : {s_axi_bresp, 32'h0}, ent[33:0]);
    end
  end

  initial begin
    void'($urandom(85878));
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    rd(CFG_ADDR, 32'h0, RESP_OKAY);
    rd(FSC_ADDR, {8'h0, FSC_RST}, RESP_OKAY);
    rd(8'hA0, 32'h0, RESP_SLVERR);
    wr(8'hA0, 32'h1, RESP_SLVERR);
    wr(IN_BASE, 32'h1, RESP_SLVERR);
    rd(IN_BASE, 32'h0, RESP_OKAY);
    $display("test reset done");
    foreach (bad[i]) begin
      cmd(bad[i], 16'h0, 32'h8001);
      clr();
    end
    cmd(CMD_ENTER, 16'h1234, 32'h8001);
    wr(8'h04, {16'h0, PASSWORD}, RESP_OKAY);
    wr(OUT_BASE, {16'h0, CMD_ENTER}, RESP_OKAY);
    repeat (8) @(posedge aclk);
    rd(IN_BASE, 32'h8001, RESP_OKAY);
    clr();
    $display("test refusals done");
    cmd(CMD_ENTER, PASSWORD, 32'hC000);
    clr();
    for (int i = 0; i < 4; i++) begin
      {flt2, flt1} <= 2'(i);
      shaft <= 20'($urandom);
      @(posedge aclk);
      img(16'(i & 1), 16'h0, 16'(shaft[19:10]), 16'(i >> 1), 16'(shaft[9:0]));
    end
    {flt2, flt1} <= 2'h0;
    cmd(CMD_ALIGN, 16'h0, 32'hC001);
    clr();
    wr(CFG_ADDR, 32'h1, RESP_OKAY);
    flt1 <= 1'h1;
    cmd(CMD_ALIGN, 16'h0, 32'hC001);
    clr();
    {flt2, flt1} <= 2'h2;
    cmd(CMD_ALIGN, 16'h0, 32'hC001);
    clr();
    flt2 <= 1'h0;
    $display("test separate positions done");
    align();
    for (int i = 0; i < 3; i++) begin
      fsc = 24'($urandom);
      shaft <= 20'($urandom);
      wr(FSC_ADDR, {8'h0, fsc}, RESP_OKAY);
      d20 = shaft - raw0 + 20'h00200;
      prod = d20 * fsc;
      img(16'h0, 16'(prod[43:36]), prod[35:20], 16'h0, 16'h0);
    end
    cmd(CMD_EXIT, 16'h0, 32'hC000);
    clr();
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rd(IN_BASE, 32'h0, RESP_OKAY);
    chk({33'h0, nvm_aligned}, 34'h0);
    $display("test aligned position done");
    @(posedge aclk);
    ce <= 1'h0;
    fork
      wr(CFG_ADDR, 32'h1, RESP_OKAY);
      begin
        repeat (4) @(posedge aclk);
        ce <= 1'h1;
      end
    join
    align();
    wr(OUT_BASE, {16'h0, CMD_SAVE_EXIT}, RESP_OKAY);
    poll(1'h1);
    rq(IN_BASE, 35'h0, d);
    chk({2'h0, d & 32'hFFFFDFFF}, 34'h9000);
    chk({14'h0, saved_q}, {14'h0, raw0 - 20'h00200});
    clr();
    rq(STAT_ADDR, 35'h0, d);
    chk({31'h0, d[2:0]}, 34'h4);
    cmd(CMD_ENTER, PASSWORD, 32'hC000);
    clr();
    cmd(CMD_EXIT, 16'h0, 32'h9000);
    clr();
    $display("test save and exit done");
    end_sim();
  end
endmodule
